// File: shared/opmode_pkg.sv
package opmode_pkg;
  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_BACKGROUND,
    MODE_WAIT,
    MODE_STOP1,
    MODE_STOP2,
    MODE_STOP3
  } op_mode_t;
  typedef enum logic [2:0] {
    CMD_MEM_ACCESS,
    CMD_MEM_STATUS,
    CMD_DBG_REG,
    CMD_BACKGROUND,
    CMD_CPU_REG,
    CMD_TRACE,
    CMD_GO
  } dbg_cmd_t;
  typedef enum logic [1:0] {
    DEPTH_STOP1,
    DEPTH_STOP2,
    DEPTH_STOP3
  } stop_depth_t;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
  localparam int PIN_COUNT = 8;
  localparam logic [PIN_COUNT-1:0] PIN_RESET_STATE = 8'h00;
endpackage

// File: hdl/stop_depth_select.sv
`timescale 1ns/1ps
`default_nettype none
module stop_depth_select (
  input wire logic power_down_select,
  input wire logic partial_power_down_select,
  input wire logic low_voltage_detect_enable,
  input wire logic low_voltage_stop_enable,
  input wire logic background_enable_bit,
  output opmode_pkg::stop_depth_t depth
);
  import opmode_pkg::*;
  wire detector_in_stop;
  wire deep_blocked;
  assign detector_in_stop = low_voltage_detect_enable & low_voltage_stop_enable;
  // Debug clocks and the detector both need the regulator up, so deep stop falls back.
  assign deep_blocked = detector_in_stop | background_enable_bit;
  assign depth = (!power_down_select || deep_blocked) ? DEPTH_STOP3 :
                 (partial_power_down_select ? DEPTH_STOP2 : DEPTH_STOP1);
endmodule // stop_depth_select
`default_nettype wire

// File: hdl/pin_state_latch.sv
`timescale 1ns/1ps
`default_nettype none
module pin_state_latch (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic capture,
  input wire logic release_req,
  input wire logic force_reset_state,
  input wire logic [opmode_pkg::PIN_COUNT-1:0] port_value,
  output logic [opmode_pkg::PIN_COUNT-1:0] pin_out,
  output logic latched
);
  import opmode_pkg::*;
  logic latched_reg;
  logic [PIN_COUNT-1:0] hold_reg;
  logic [PIN_COUNT-1:0] pin_reg;
  wire [PIN_COUNT-1:0] pin_next;
  // Capture wins over a release in the same cycle so a fresh stop2 entry is never lost.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      latched_reg <= 1'b0;
    end else if (capture) begin
      latched_reg <= 1'b1;
    end else if (release_req) begin
      latched_reg <= 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hold_reg <= PIN_RESET_STATE;
    end else if (capture && !latched_reg) begin
      hold_reg <= port_value;
    end
  end
  assign pin_next = force_reset_state ? PIN_RESET_STATE :
                    (latched_reg ? hold_reg : port_value);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_reg <= PIN_RESET_STATE;
    end else begin
      pin_reg <= pin_next;
    end
  end
  assign pin_out = pin_reg;
  assign latched = latched_reg;
endmodule // pin_state_latch
`default_nettype wire

// File: hdl/operating_mode_controller.sv
// What this block does
// - Mode pin high at reset: run, vector
// - Five triggers enter background mode
// - Background mode suspends CPU execution
// - Debug commands gated by current mode
// - Wait gates CPU clock, clears mask
// - Interrupt ends wait into stacking
// - Wait: background and status commands only
// - Background command wakes wait to background
// - Enabled stop enters stop, CPU and system clocks halted
// - Disabled stop forces illegal-opcode reset
// - Select bits choose stop depth
// - Deep stop only without detector in stop
// - Stop1 powers off, wakes by reset/interrupt
// - Stop1 asserts detect, waits supply recovery
// - Stop1 wake acts as power-on reset
// - Stop2 keeps RAM, three wake sources
// - Stop2 latches pins until acknowledge
// - Stop2 wake resets all but pins
// - Stop2 wake sets flag until acknowledge
// - Released pins follow port registers
// - Stop3 keeps RAM powered, pins not latched
// - Debug or detector forces stop3 instead
// - Stop3 exits by reset, interrupts, periodic
`timescale 1ns/1ps
`default_nettype none
module operating_mode_controller (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic debug_mode_select_pin,
  input wire logic stop_instruction,
  input wire logic wait_instruction,
  input wire logic background_halt_instruction,
  input wire logic debug_controller_breakpoint,
  input wire logic on_chip_breakpoint_module,
  input wire logic stop_enable_bit,
  input wire logic power_down_select,
  input wire logic partial_power_down_select,
  input wire logic low_voltage_detect_enable,
  input wire logic low_voltage_stop_enable,
  input wire logic background_enable_bit,
  input wire logic partial_power_down_ack,
  input wire logic supply_recovered,
  input wire logic reset_pin_wake,
  input wire logic irq_pin_n,
  input wire logic keyboard_interrupt,
  input wire logic periodic_wakeup_interrupt,
  input wire logic interrupt_request,
  input wire logic dbg_cmd_valid,
  input wire opmode_pkg::dbg_cmd_t dbg_cmd,
  input wire logic [opmode_pkg::PIN_COUNT-1:0] port_value,
  output opmode_pkg::op_mode_t current_mode,
  output logic cpu_clock_enable,
  output logic system_clock_enable,
  output logic debug_clock_enable,
  output logic regulator_on,
  output logic ram_retained,
  output logic clear_interrupt_mask,
  output logic start_stacking,
  output logic fetch_vector,
  output logic [15:0] vector_addr,
  output logic illegal_opcode_reset,
  output logic power_on_reset_req,
  output logic low_voltage_detect,
  output logic partial_power_down_flag,
  output logic dbg_cmd_accept,
  output logic dbg_cmd_status_error,
  output logic dbg_cmd_reject,
  output logic [opmode_pkg::PIN_COUNT-1:0] pin_out,
  output logic pins_latched
);
  import opmode_pkg::*;
  op_mode_t mode_reg, mode_next;
  logic boot_pending_reg;
  logic ppd_flag_reg;
  logic lv_detect_reg;
  logic wake_pending_reg;
  logic stacking_reg;
  logic vector_reg;
  logic illegal_reg;
  logic por_reg;
  logic mask_clear_reg;
  logic accept_reg;
  logic status_err_reg;
  logic reject_reg;
  stop_depth_t depth;
  wire in_stop;
  wire bg_cmd;
  wire enter_background;
  wire irq_active;
  wire stop_ok;
  wire stop1_wake;
  wire stop2_wake;
  wire stop3_reset_wake;
  wire stop3_int_wake;
  wire cmd_nonintrusive;
  wire cmd_active_only;
  wire latch_capture;
  wire latch_release;

  function automatic logic is_stop(input op_mode_t m);
    is_stop = (m == MODE_STOP1) || (m == MODE_STOP2) || (m == MODE_STOP3);
  endfunction

  stop_depth_select u_depth (
    .power_down_select(power_down_select),
    .partial_power_down_select(partial_power_down_select),
    .low_voltage_detect_enable(low_voltage_detect_enable),
    .low_voltage_stop_enable(low_voltage_stop_enable),
    .background_enable_bit(background_enable_bit),
    .depth(depth)
  );

  assign in_stop = is_stop(mode_reg);
  assign bg_cmd = dbg_cmd_valid && (dbg_cmd == CMD_BACKGROUND);
  assign irq_active = !irq_pin_n;
  assign stop_ok = stop_instruction && stop_enable_bit;
  assign enter_background = bg_cmd || background_halt_instruction ||
                            debug_controller_breakpoint || on_chip_breakpoint_module;
  // The detect condition must drop before stop1 may leave; a wake pin alone is not enough.
  assign stop1_wake = (reset_pin_wake || irq_active) && supply_recovered;
  assign stop2_wake = reset_pin_wake || irq_active || periodic_wakeup_interrupt;
  assign stop3_reset_wake = reset_pin_wake;
  assign stop3_int_wake = irq_active || keyboard_interrupt || periodic_wakeup_interrupt;
  assign cmd_nonintrusive = (dbg_cmd == CMD_MEM_ACCESS) || (dbg_cmd == CMD_MEM_STATUS) ||
                            (dbg_cmd == CMD_DBG_REG) || (dbg_cmd == CMD_BACKGROUND);
  assign cmd_active_only = (dbg_cmd == CMD_CPU_REG) || (dbg_cmd == CMD_TRACE) ||
                           (dbg_cmd == CMD_GO);
  // Background entry outranks stop, so the pins must not be frozen on that cycle.
  assign latch_capture = (mode_reg == MODE_RUN) && stop_ok && !enter_background &&
                         (depth == DEPTH_STOP2);
  assign latch_release = partial_power_down_ack;

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_RUN: begin
        if (enter_background) begin
          mode_next = MODE_BACKGROUND;
        end else if (stop_ok) begin
          case (depth)
            DEPTH_STOP1: mode_next = MODE_STOP1;
            DEPTH_STOP2: mode_next = MODE_STOP2;
            default: mode_next = MODE_STOP3;
          endcase
        end else if (wait_instruction) begin
          mode_next = MODE_WAIT;
        end
      end
      MODE_BACKGROUND: begin
        if (dbg_cmd_valid && (dbg_cmd == CMD_GO)) begin
          mode_next = MODE_RUN;
        end
      end
      MODE_WAIT: begin
        if (bg_cmd) begin
          mode_next = MODE_BACKGROUND;
        end else if (interrupt_request) begin
          mode_next = MODE_RUN;
        end
      end
      MODE_STOP1: begin
        if (stop1_wake) begin
          mode_next = MODE_RUN;
        end
      end
      MODE_STOP2: begin
        if (stop2_wake) begin
          mode_next = MODE_RUN;
        end
      end
      MODE_STOP3: begin
        if (bg_cmd && background_enable_bit) begin
          mode_next = MODE_BACKGROUND;
        end else if (stop3_reset_wake || stop3_int_wake) begin
          mode_next = MODE_RUN;
        end
      end
      default: mode_next = MODE_RUN;
    endcase
  end

  // The mode pin is only sampled after reset release, never loaded under the reset itself.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= MODE_RUN;
      boot_pending_reg <= 1'b1;
    end else if (boot_pending_reg) begin
      mode_reg <= debug_mode_select_pin ? MODE_RUN : MODE_BACKGROUND;
      boot_pending_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Flag set by stop2 wake wins over a simultaneous acknowledge.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ppd_flag_reg <= 1'b0;
    end else if ((mode_reg == MODE_STOP2) && stop2_wake) begin
      ppd_flag_reg <= 1'b1;
    end else if (partial_power_down_ack) begin
      ppd_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lv_detect_reg <= 1'b0;
    end else if (mode_next == MODE_STOP1 && mode_reg != MODE_STOP1) begin
      lv_detect_reg <= 1'b1;
    end else if (supply_recovered) begin
      lv_detect_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wake_pending_reg <= 1'b0;
      stacking_reg <= 1'b0;
      vector_reg <= 1'b0;
      illegal_reg <= 1'b0;
      por_reg <= 1'b0;
      mask_clear_reg <= 1'b0;
    end else begin
      wake_pending_reg <= 1'b0;
      stacking_reg <= ((mode_reg == MODE_WAIT) && (mode_next == MODE_RUN)) ||
                      ((mode_reg == MODE_STOP3) && (mode_next == MODE_RUN) &&
                       !stop3_reset_wake);
      vector_reg <= (boot_pending_reg && debug_mode_select_pin) ||
                    (((mode_reg == MODE_STOP1) || (mode_reg == MODE_STOP2)) &&
                     (mode_next == MODE_RUN)) ||
                    ((mode_reg == MODE_STOP3) && (mode_next == MODE_RUN) &&
                     stop3_reset_wake);
      illegal_reg <= (mode_reg == MODE_RUN) && stop_instruction && !stop_enable_bit;
      por_reg <= ((mode_reg == MODE_STOP1) || (mode_reg == MODE_STOP2)) &&
                 (mode_next == MODE_RUN);
      mask_clear_reg <= (mode_reg == MODE_RUN) && (mode_next == MODE_WAIT);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      accept_reg <= 1'b0;
      status_err_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else begin
      accept_reg <= 1'b0;
      status_err_reg <= 1'b0;
      reject_reg <= 1'b0;
      if (dbg_cmd_valid) begin
        case (mode_reg)
          MODE_RUN: begin
            accept_reg <= cmd_nonintrusive;
            reject_reg <= cmd_active_only;
          end
          MODE_BACKGROUND: accept_reg <= 1'b1;
          MODE_WAIT, MODE_STOP3: begin
            // Status commands answer with an error and never touch memory here.
            accept_reg <= bg_cmd;
            status_err_reg <= (dbg_cmd == CMD_MEM_STATUS);
            reject_reg <= !bg_cmd && (dbg_cmd != CMD_MEM_STATUS);
          end
          default: reject_reg <= 1'b1;
        endcase
      end
    end
  end

  pin_state_latch u_pins (
    .mclk(mclk),
    .arst_n(arst_n),
    .capture(latch_capture),
    .release_req(latch_release),
    .force_reset_state(mode_reg == MODE_STOP1),
    .port_value(port_value),
    .pin_out(pin_out),
    .latched(pins_latched)
  );

  assign current_mode = mode_reg;
  assign cpu_clock_enable = (mode_reg == MODE_RUN) && !boot_pending_reg;
  assign system_clock_enable = !in_stop;
  assign debug_clock_enable = !in_stop || background_enable_bit;
  assign regulator_on = !in_stop || ((mode_reg == MODE_STOP3) &&
                        (background_enable_bit ||
                         (low_voltage_detect_enable && low_voltage_stop_enable)));
  assign ram_retained = (mode_reg != MODE_STOP1);
  assign clear_interrupt_mask = mask_clear_reg;
  assign start_stacking = stacking_reg;
  assign fetch_vector = vector_reg;
  assign vector_addr = RESET_VECTOR_ADDR;
  assign illegal_opcode_reset = illegal_reg;
  assign power_on_reset_req = por_reg;
  assign low_voltage_detect = lv_detect_reg;
  assign partial_power_down_flag = ppd_flag_reg;
  assign dbg_cmd_accept = accept_reg;
  assign dbg_cmd_status_error = status_err_reg;
  assign dbg_cmd_reject = reject_reg;
endmodule // operating_mode_controller
`default_nettype wire

// File: testbench/opmode_checker.sv
`timescale 1ns/1ps
`default_nettype none
module opmode_checker (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic interrupt_request,
  input wire logic dbg_cmd_valid,
  input wire opmode_pkg::dbg_cmd_t dbg_cmd,
  input wire logic supply_recovered,
  input wire logic partial_power_down_ack,
  input wire opmode_pkg::op_mode_t current_mode,
  input wire logic cpu_clock_enable,
  input wire logic system_clock_enable,
  input wire logic start_stacking,
  input wire logic dbg_cmd_status_error,
  input wire logic partial_power_down_flag,
  input wire logic pins_latched
);
  import opmode_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire in_wait = current_mode == MODE_WAIT;
  wire in_stop = current_mode inside {MODE_STOP1, MODE_STOP2, MODE_STOP3};
  wire cmd_bg = dbg_cmd_valid && dbg_cmd == CMD_BACKGROUND;
  wire cmd_st = dbg_cmd_valid && dbg_cmd == CMD_MEM_STATUS;
  wire flag = partial_power_down_flag;
  a_wait_clocks: assert property (
    in_wait |-> !cpu_clock_enable && system_clock_enable) else $error("wait clocks wrong");
  a_stop_clocks: assert property (
    in_stop |-> !system_clock_enable) else $error("clock runs in stop");
  a_wait_irq_exit: assert property (
    in_wait && interrupt_request && !dbg_cmd_valid |=> current_mode == MODE_RUN ##[0:1]
    start_stacking) else $error("interrupt did not end wait");
  a_wait_bg_wake: assert property (
    in_wait && cmd_bg |=> current_mode == MODE_BACKGROUND) else $error("no wake to debug");
  a_wait_status_err: assert property (
    in_wait && cmd_st |-> ##[1:2] dbg_cmd_status_error) else $error("status error missing");
  a_stop1_held: assert property (
    current_mode == MODE_STOP1 && !supply_recovered |=> current_mode == MODE_STOP1)
    else $error("stop1 left before supply recovery");
  a_flag_held: assert property (
    flag && !partial_power_down_ack |=> flag) else $error("flag dropped without ack");
  a_ack_opens: assert property (
    flag && partial_power_down_ack && current_mode != MODE_STOP2 |=> !flag && !pins_latched)
    else $error("ack did not open latches");
  c_stop2: cover property (current_mode == MODE_STOP2);
  c_wait_irq: cover property (in_wait && interrupt_request);
  c_ack: cover property (flag && partial_power_down_ack);
endmodule // opmode_checker
bind operating_mode_controller opmode_checker chk_i (
  .mclk(mclk), .arst_n(arst_n), .interrupt_request(interrupt_request),
  .dbg_cmd_valid(dbg_cmd_valid), .dbg_cmd(dbg_cmd), .supply_recovered(supply_recovered),
  .partial_power_down_ack(partial_power_down_ack), .current_mode(current_mode),
  .cpu_clock_enable(cpu_clock_enable), .system_clock_enable(system_clock_enable),
  .start_stacking(start_stacking), .dbg_cmd_status_error(dbg_cmd_status_error),
  .partial_power_down_flag(partial_power_down_flag), .pins_latched(pins_latched)
);
`default_nettype wire

// File: testbench/debug_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module debug_host_model (
  input wire logic mclk,
  output logic dbg_cmd_valid,
  output opmode_pkg::dbg_cmd_t dbg_cmd,
  output logic irq_pin_n,
  output logic periodic_wakeup_interrupt,
  output logic keyboard_interrupt,
  output logic reset_pin_wake
);
  import opmode_pkg::*;
  logic [3:0] src = 4'h0;
  assign irq_pin_n = ~src[0];
  assign periodic_wakeup_interrupt = src[1];
  assign keyboard_interrupt = src[2];
  assign reset_pin_wake = src[3];
  initial begin
    dbg_cmd_valid = 1'b0;
    dbg_cmd = CMD_GO;
  end
  // The host sends any command in any mode, since gating them is the device's job.
  task automatic send(input dbg_cmd_t c, input int slow);
    repeat (slow) @(posedge mclk);
    @(posedge mclk);
    dbg_cmd_valid <= 1'b1;
    dbg_cmd <= c;
    @(posedge mclk);
    dbg_cmd_valid <= 1'b0;
    dbg_cmd <= dbg_cmd_t'(~c);
  endtask
  task automatic wake(input int k);
    @(posedge mclk);
    src[k] <= 1'b1;
    repeat (3) @(posedge mclk);
    src <= 4'h0;
  endtask
endmodule // debug_host_model
`default_nettype wire

// File: testbench/operating_mode_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module operating_mode_controller_tb_top;
  import opmode_pkg::*;
  logic mclk, arst_n, msp, supply, irq;
  logic [5:0] ins, cfg;
  logic [7:0] port, seen, pins;
  logic [15:0] vec;
  logic valid, irq_n, rtw, kbw, rstw, cpu_en, sys_en, reg_on, ram_on, clr_i, stk, fv;
  logic ill, por, lv_det, flag, acc, serr, rej, latched, dbg_en;
  dbg_cmd_t cmd;
  op_mode_t mode;
  int err_count, num_checks;
  operating_mode_controller dut (
    .mclk(mclk), .arst_n(arst_n), .debug_mode_select_pin(msp), .stop_instruction(ins[0]),
    .wait_instruction(ins[1]), .background_halt_instruction(ins[2]),
    .debug_controller_breakpoint(ins[3]),
    .on_chip_breakpoint_module(ins[4]), .partial_power_down_ack(ins[5]),
    .stop_enable_bit(cfg[0]), .power_down_select(cfg[1]), .partial_power_down_select(cfg[2]),
    .low_voltage_detect_enable(cfg[3]), .low_voltage_stop_enable(cfg[4]),
    .background_enable_bit(cfg[5]), .supply_recovered(supply), .reset_pin_wake(rstw),
    .irq_pin_n(irq_n), .keyboard_interrupt(kbw), .periodic_wakeup_interrupt(rtw),
    .interrupt_request(irq), .dbg_cmd_valid(valid), .dbg_cmd(cmd), .port_value(port),
    .current_mode(mode), .cpu_clock_enable(cpu_en), .system_clock_enable(sys_en),
    .debug_clock_enable(dbg_en), .regulator_on(reg_on), .ram_retained(ram_on),
    .clear_interrupt_mask(clr_i), .start_stacking(stk), .fetch_vector(fv), .vector_addr(vec),
    .illegal_opcode_reset(ill), .power_on_reset_req(por), .low_voltage_detect(lv_det),
    .partial_power_down_flag(flag), .dbg_cmd_accept(acc), .dbg_cmd_status_error(serr),
    .dbg_cmd_reject(rej), .pin_out(pins), .pins_latched(latched));
  debug_host_model h (.mclk(mclk), .dbg_cmd_valid(valid), .dbg_cmd(cmd), .irq_pin_n(irq_n),
    .periodic_wakeup_interrupt(rtw), .keyboard_interrupt(kbw), .reset_pin_wake(rstw));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Pulses are gathered at the falling edge, clear of the edge that launches them.
  always @(negedge mclk) seen = seen | {fv, clr_i, stk, ill, por, acc, serr, rej};
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_mode(input op_mode_t e);
    int n;
    n = 0;
    while (mode !== e && n < 8) begin
      @(negedge mclk);
      n++;
    end
    chk(16'(mode), 16'(e));
    if (mode !== e) results();
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    ins[i] <= 1'b1;
    @(posedge mclk);
    ins <= 6'h00;
  endtask
  task automatic saw(input logic [7:0] e);
    repeat (3) @(negedge mclk);
    chk(seen, e);
    seen = 8'h00;
  endtask
  task automatic t_boot(input logic p);
    @(posedge mclk);
    arst_n <= 1'b0;
    msp <= p;
    cfg <= 6'h00;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    seen = 8'h00;
    wait_mode(p ? MODE_RUN : MODE_BACKGROUND);
    saw(p ? 8'h80 : 8'h00);
  endtask
  task automatic t_debug;
    t_boot(1'b0);
    chk(cpu_en, 1'b0);
    h.send(CMD_CPU_REG, 0);
    saw(8'h04);
    t_boot(1'b1);
    h.send(CMD_TRACE, 3);
    h.send(CMD_MEM_ACCESS, 0);
    saw(8'h05);
    pulse(2);
    wait_mode(MODE_BACKGROUND);
    h.send(CMD_GO, 0);
    wait_mode(MODE_RUN);
    chk(cpu_en, 1'b1);
    pulse(3);
    wait_mode(MODE_BACKGROUND);
    t_boot(1'b1);
    pulse(4);
    wait_mode(MODE_BACKGROUND);
    t_boot(1'b1);
    h.send(CMD_BACKGROUND, 0);
    wait_mode(MODE_BACKGROUND);
  endtask
  task automatic t_wait;
    t_boot(1'b1);
    pulse(1);
    wait_mode(MODE_WAIT);
    saw(8'h40);
    chk({cpu_en, sys_en}, 2'b01);
    h.send(CMD_MEM_STATUS, 0);
    h.send(CMD_DBG_REG, 0);
    saw(8'h03);
    @(posedge mclk);
    irq <= 1'b1;
    wait_mode(MODE_RUN);
    @(posedge mclk);
    irq <= 1'b0;
    saw(8'h20);
    pulse(1);
    wait_mode(MODE_WAIT);
    h.send(CMD_BACKGROUND, 0);
    wait_mode(MODE_BACKGROUND);
    t_boot(1'b1);
    pulse(0);
    saw(8'h10);
    chk(16'(mode), 16'(MODE_RUN));
  endtask
  task automatic t_stop2;
    @(posedge mclk);
    port <= 8'hA5;
    cfg <= 6'h07;
    pulse(0);
    wait_mode(MODE_STOP2);
    chk({sys_en, latched, pins}, 10'h1A5);
    @(posedge mclk);
    port <= 8'h3C;
    h.wake(0);
    wait_mode(MODE_RUN);
    saw(8'h88);
    chk({flag, latched, pins}, 10'h3A5);
    pulse(5);
    repeat (2) @(negedge mclk);
    chk({flag, latched, pins}, 10'h03C);
  endtask
  task automatic t_stop1;
    t_boot(1'b1);
    @(posedge mclk);
    cfg <= 6'h03;
    supply <= 1'b0;
    pulse(0);
    wait_mode(MODE_STOP1);
    // Pins reach their reset state one cycle after the mode, as they come from a flip-flop.
    @(negedge mclk);
    chk({lv_det, reg_on, ram_on, dbg_en, pins}, 12'h800);
    h.wake(1);
    h.wake(0);
    chk(16'(mode), 16'(MODE_STOP1));
    h.send(CMD_MEM_ACCESS, 0);
    saw(8'h01);
    @(posedge mclk);
    supply <= 1'b1;
    h.wake(0);
    wait_mode(MODE_RUN);
    saw(8'h88);
    chk(lv_det, 1'b0);
  endtask
  task automatic t_stop3;
    t_boot(1'b1);
    @(posedge mclk);
    cfg <= 6'h27;
    pulse(0);
    wait_mode(MODE_STOP3);
    chk({sys_en, latched, dbg_en, reg_on}, 4'b0011);
    h.wake(1);
    wait_mode(MODE_RUN);
    @(posedge mclk);
    cfg <= 6'h1B;
    pulse(0);
    wait_mode(MODE_STOP3);
    h.wake(2);
    wait_mode(MODE_RUN);
    repeat (3) @(negedge mclk);
    chk(seen & 8'hB8, 8'h20);
    seen = 8'h00;
    pulse(0);
    wait_mode(MODE_STOP3);
    h.wake(3);
    wait_mode(MODE_RUN);
    saw(8'h80);
  endtask
  initial begin
    {arst_n, msp, irq, ins, cfg, port, seen} = '0;
    supply = 1'b1;
    err_count = 0;
    num_checks = 0;
    t_boot(1'b1);
    chk(vec, 16'hFFFE);
    t_debug;
    t_wait;
    t_stop2;
    t_stop1;
    t_stop3;
    results();
  end
endmodule // operating_mode_controller_tb_top
`default_nettype wire
